// *** rtl/spi_switch_regs.sv ***
// Serially controlled quad switch register bank with error detection and software reset
`include "spi_sw_consts.svh"
`timescale 1ns/1ps
module spi_switch_regs (
  input  wire logic                core_clk_i,
  input  wire logic                resetn_i,
  input  wire logic                spi_sclk_i,
  input  wire logic                spi_cs_n_i,
  input  wire logic                spi_sdi_i,
  output logic                     spi_sdo_o,
  output logic                     spi_sdo_oe_o,
  output spi_sw_pkg::switch_vec_t  switch_close_o
);
  import spi_sw_pkg::*;
  default clocking dcb @(posedge core_clk_i);
  endclocking
  default disable iff (!resetn_i);

  logic [2:0]   pin_sync;
  logic         cs_n, sclk, sdi, sclk_q, cs_q;
  logic         sclk_rise, sclk_fall, cs_fall, cs_rise;
  frame_state_t state;
  logic [4:0]   bit_idx, idx_next, frame_len;
  logic [9:0]   bit_total;
  logic [22:0]  shift_in;
  logic [23:0]  rx_word;
  logic         crc_on, burst_on, burst_reg, crc_req, cmd_rw;
  logic [6:0]   cmd_addr, wr_addr;
  logic [15:0]  payload;
  logic         is_write, is_clear, crc_ok, at_frame_end, commit, clear_go;
  logic         crc_bad, addr_bad9, addr_bad_clr, clk_bad, soft_rst_go, key_armed;
  reg_byte_t    wr_data, rst_key, read_data, tx_byte;
  logic [3:0]   wr_low;
  logic [2:0]   err_en, flags, next_flags;
  logic [2:0]   tx_pos, pos_n;

  // ********************************************************************
  // Helper functions
  // ********************************************************************
  function automatic reg_byte_t crc8_word(input logic [15:0] d);
    reg_byte_t c;
    logic      fb;
    c = `CRC_SEED;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7] ^ d[i];
      c  = {c[6:0], 1'b0} ^ (fb ? `CRC_POLY : 8'h00);
    end
    return c;
  endfunction

  function automatic logic addr_ok(input logic rw, input logic [6:0] addr);
    case (addr)
      `ADDR_SWITCH, `ADDR_ERR_EN, `ADDR_BURST, `ADDR_RST_KEY: addr_ok = 1'b1;
      `ADDR_ERR_FLAGS: addr_ok = (rw != `RW_WRITE);
      default: addr_ok = 1'b0;
    endcase
  endfunction

  // ********************************************************************
  // Pin synchronisation and edge detection
  // ********************************************************************
  pin_filter #(.WIDTH(3), .RST_VAL(3'h4)) u_pins (
    .core_clk_i (core_clk_i),
    .resetn_i   (resetn_i),
    .pins_i     ({spi_cs_n_i, spi_sclk_i, spi_sdi_i}),
    .pins_o     (pin_sync)
  );

  assign cs_n      = pin_sync[2];
  assign sclk      = pin_sync[1];
  assign sdi       = pin_sync[0];
  assign sclk_rise = !cs_n && sclk && !sclk_q;
  assign sclk_fall = !cs_n && !sclk && sclk_q;
  assign cs_fall   = !cs_n && cs_q;
  assign cs_rise   = cs_n && !cs_q;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      sclk_q <= 1'b0;
      cs_q   <= 1'b1;
    end else begin
      sclk_q <= sclk;
      cs_q   <= cs_n;
    end
  end

  // ********************************************************************
  // Frame decode
  // ********************************************************************
  assign idx_next  = bit_idx + 5'h01;
  assign rx_word   = {shift_in, sdi};
  assign frame_len = crc_on ? `LEN_CRC : `LEN_PLAIN;
  assign payload   = crc_on ? rx_word[23:8] : rx_word[15:0];
  assign is_write  = (payload[15] == `RW_WRITE);
  assign wr_addr   = payload[14:8];
  assign wr_data   = payload[7:0];
  assign wr_low    = wr_data[3:0];
  assign is_clear  = (payload == `CLEAR_WORD);
  assign crc_ok    = !crc_on || (crc8_word(payload) == rx_word[7:0]);
  assign crc_req   = err_en[`BIT_CRC_CHK];

  assign at_frame_end = (state == st_shift) && sclk_rise && (idx_next == frame_len);
  assign commit       = at_frame_end && is_write && !is_clear && crc_ok &&
                        addr_ok(`RW_WRITE, wr_addr);
  assign clear_go     = at_frame_end && is_clear && crc_ok;
  assign crc_bad      = at_frame_end && crc_on && is_write && !crc_ok;
  assign addr_bad9    = (state == st_shift) && sclk_rise && (idx_next == `EDGE_ADDR_CHK) &&
                        err_en[`BIT_ADDR_CHK] && !addr_ok(cmd_rw, cmd_addr) &&
                        !(cmd_rw == `RW_WRITE && cmd_addr == `ADDR_CLEAR);
  assign addr_bad_clr = at_frame_end && err_en[`BIT_ADDR_CHK] && is_write &&
                        (wr_addr == `ADDR_CLEAR) && !is_clear;
  assign clk_bad      = cs_rise && (state != st_idle) && err_en[`BIT_CLK_CHK] &&
                        (burst_on ? (bit_idx != 5'h00 || bit_total == 10'h000)
                                  : (bit_total != {5'h00, frame_len}));
  assign soft_rst_go  = commit && key_armed && (wr_addr == `ADDR_RST_KEY) &&
                        (wr_data == `KEY_SECOND);

  // ********************************************************************
  // Frame sequencing
  // ********************************************************************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      state    <= st_idle;
      bit_idx  <= 5'h00;
      crc_on   <= 1'b0;
      burst_on <= 1'b0;
    end else if (cs_rise) begin
      state <= st_idle;
    end else begin
      case (state)
        st_idle: begin
          if (cs_fall) begin
            state    <= st_shift;
            bit_idx  <= 5'h00;
            crc_on   <= crc_req;
            burst_on <= burst_reg;
          end
        end
        st_shift: begin
          if (sclk_rise) begin
            if (idx_next == frame_len) begin
              bit_idx <= 5'h00;
              state   <= burst_on ? st_shift : st_hold;
            end else begin
              bit_idx <= idx_next;
            end
          end
        end
        st_hold: state <= st_hold;
        default: state <= st_idle;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      shift_in  <= 23'h000000;
      bit_total <= 10'h000;
      cmd_rw    <= 1'b0;
      cmd_addr  <= 7'h00;
    end else if (cs_fall) begin
      bit_total <= 10'h000;
    end else if (sclk_rise) begin
      shift_in <= rx_word[22:0];
      if (bit_total != `TOTAL_MAX) begin
        bit_total <= bit_total + 10'h001;
      end
      if (state == st_shift && idx_next == `EDGE_ADDR) begin
        cmd_rw   <= rx_word[7];
        cmd_addr <= rx_word[6:0];
      end
    end
  end

  // ********************************************************************
  // Registers
  // ********************************************************************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      switch_close_o <= `RST_SWITCH;
      err_en         <= `RST_ERR_EN;
      burst_reg      <= `RST_BURST;
      rst_key        <= `RST_KEY;
    end else if (soft_rst_go) begin
      switch_close_o <= `RST_SWITCH;
      err_en         <= `RST_ERR_EN;
      burst_reg      <= `RST_BURST;
      rst_key        <= `RST_KEY;
    end else if (commit) begin
      case (wr_addr)
        `ADDR_SWITCH:  switch_close_o <= wr_low;
        `ADDR_ERR_EN:  err_en         <= wr_data[2:0];
        `ADDR_BURST:   burst_reg      <= wr_data[0];
        `ADDR_RST_KEY: rst_key        <= wr_data;
        default:       rst_key        <= rst_key;
      endcase
    end
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      key_armed <= 1'b0;
    end else if (at_frame_end) begin
      key_armed <= commit && (wr_addr == `ADDR_RST_KEY) &&
                   (wr_data == `KEY_FIRST) && !soft_rst_go;
    end
  end

  always_comb begin
    next_flags                = clear_go ? `RST_FLAGS : flags;
    next_flags[`FLAG_ADDR]    = next_flags[`FLAG_ADDR] | addr_bad9 | addr_bad_clr;
    next_flags[`FLAG_CLK]     = next_flags[`FLAG_CLK] | clk_bad;
    next_flags[`FLAG_CRC]     = next_flags[`FLAG_CRC] | crc_bad;
  end

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      flags <= `RST_FLAGS;
    end else if (soft_rst_go) begin
      flags <= `RST_FLAGS;
    end else begin
      flags <= next_flags;
    end
  end

  always_comb begin
    case (rx_word[6:0])
      `ADDR_SWITCH:    read_data = {4'h0, switch_close_o};
      `ADDR_ERR_EN:    read_data = {5'h00, err_en};
      `ADDR_ERR_FLAGS: read_data = {5'h00, flags};
      `ADDR_BURST:     read_data = {7'h00, burst_reg};
      `ADDR_RST_KEY:   read_data = rst_key;
      default:         read_data = 8'h00;
    endcase
  end

  // ********************************************************************
  // Serial output
  // ********************************************************************
  assign pos_n = tx_pos + 3'h1;

  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      tx_byte      <= `ALIGN_BYTE;
      tx_pos       <= 3'h0;
      spi_sdo_o    <= 1'b0;
      spi_sdo_oe_o <= 1'b0;
    end else begin
      spi_sdo_oe_o <= !cs_n;
      if (cs_fall) begin
        tx_byte   <= `ALIGN_BYTE;
        tx_pos    <= 3'h0;
        spi_sdo_o <= 1'(`ALIGN_BYTE >> 7);
      end else if (sclk_fall) begin
        tx_pos    <= pos_n;
        spi_sdo_o <= tx_byte[3'h7 - pos_n];
      end else if (sclk_rise && state == st_shift) begin
        if (at_frame_end) begin
          tx_byte <= `ALIGN_BYTE;
        end else if (idx_next == `EDGE_ADDR) begin
          tx_byte <= read_data;
        end else if (idx_next == `LEN_PLAIN) begin
          tx_byte <= crc8_word({cmd_rw, cmd_addr, tx_byte});
        end
      end
    end
  end

  // ********************************************************************
  // Assertions
  // ********************************************************************
  property p_switch_write;
    commit && (wr_addr == `ADDR_SWITCH) |=> switch_close_o == $past(wr_low);
  endproperty
  a_switch_write: assert property (p_switch_write) else $error("switch write lost");
  property p_soft_defaults;
    soft_rst_go |=> (err_en == `RST_ERR_EN) && (switch_close_o == `RST_SWITCH) && !burst_reg;
  endproperty
  a_soft_defaults: assert property (p_soft_defaults) else $error("defaults not restored");
  property p_crc_latch;
    (state == st_idle) && cs_fall && !cs_rise |=> crc_on == $past(crc_req);
  endproperty
  a_crc_latch: assert property (p_crc_latch) else $error("checksum mode not latched");
  property p_flags_upper;
    (rx_word[6:0] == `ADDR_ERR_FLAGS) |-> (read_data[7:3] == 5'h00) && (read_data[2:0] == flags);
  endproperty
  a_flags_upper: assert property (p_flags_upper) else $error("flag readback wrong");
  property p_clear;
    clear_go && !clk_bad |=> flags == `RST_FLAGS;
  endproperty
  a_clear: assert property (p_clear) else $error("flags not cleared");
  property p_addr_flag;
    addr_bad9 |=> flags[`FLAG_ADDR] ##1 !commit;
  endproperty
  a_addr_flag: assert property (p_addr_flag) else $error("address flag missed");
  property p_clk_flag;
    clk_bad |=> flags[`FLAG_CLK] && (state == st_idle);
  endproperty
  a_clk_flag: assert property (p_clk_flag) else $error("clock count flag missed");
  property p_crc_flag;
    crc_bad |-> !commit ##1 flags[`FLAG_CRC];
  endproperty
  a_crc_flag: assert property (p_crc_flag) else $error("checksum flag missed");
  property p_burst_only;
    commit && (bit_total >= 10'h018) |-> burst_on;
  endproperty
  a_burst_only: assert property (p_burst_only) else $error("second frame without burst");
  property p_commit_edge;
    commit |-> (idx_next == (crc_on ? `LEN_CRC : `LEN_PLAIN)) && crc_ok;
  endproperty
  a_commit_edge: assert property (p_commit_edge) else $error("write at wrong edge");
  property p_key_order;
    soft_rst_go |-> key_armed ##1 !key_armed;
  endproperty
  a_key_order: assert property (p_key_order) else $error("reset without first key");

endmodule

// *** rtl/spi_sw_consts.svh ***
// Register map, field positions, reset values and frame counts of the switch register bank
`ifndef SPI_SW_CONSTS_SVH
`define SPI_SW_CONSTS_SVH

// ********************************************************************
// Register addresses
// ********************************************************************
`define ADDR_SWITCH     7'h01
`define ADDR_ERR_EN     7'h02
`define ADDR_ERR_FLAGS  7'h03
`define ADDR_BURST      7'h05
`define ADDR_RST_KEY    7'h0b
`define ADDR_CLEAR      7'h6c

// ********************************************************************
// Reset values
// ********************************************************************
`define RST_SWITCH      4'h0
`define RST_ERR_EN      3'h6
`define RST_FLAGS       3'h0
`define RST_BURST       1'h0
`define RST_KEY         8'h00

// ********************************************************************
// Field positions
// ********************************************************************
`define BIT_ADDR_CHK    2
`define BIT_CLK_CHK     1
`define BIT_CRC_CHK     0
`define FLAG_ADDR       2
`define FLAG_CLK        1
`define FLAG_CRC        0

// ********************************************************************
// Frame figures and special words
// ********************************************************************
`define LEN_PLAIN       5'h10
`define LEN_CRC         5'h18
`define EDGE_ADDR       5'h08
`define EDGE_ADDR_CHK   5'h09
`define CLEAR_WORD      16'h6ca9
`define ALIGN_BYTE      8'h25
`define KEY_FIRST       8'ha3
`define KEY_SECOND      8'h05
`define CRC_POLY        8'h07
`define CRC_SEED        8'h00
`define RW_WRITE        1'h0
`define TOTAL_MAX       10'h3ff

`endif

// *** rtl/spi_sw_pkg.sv ***
// Types shared by the switch register bank
package spi_sw_pkg;
  typedef enum logic [1:0] {st_idle, st_shift, st_hold} frame_state_t;
  typedef logic [3:0] switch_vec_t;
  typedef logic [7:0] reg_byte_t;
endpackage

// *** rtl/pin_filter.sv ***
// Three-stage pin synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
module pin_filter #(
  parameter int             WIDTH   = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '0
) (
  input  wire logic             core_clk_i,
  input  wire logic             resetn_i,
  input  wire logic [WIDTH-1:0] pins_i,
  output logic      [WIDTH-1:0] pins_o
);

  logic [WIDTH-1:0] stage1;
  logic [WIDTH-1:0] stage2;
  logic [WIDTH-1:0] stage3;

  // ********************************************************************
  // Synchroniser chain
  // ********************************************************************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      stage1 <= RST_VAL;
      stage2 <= RST_VAL;
      stage3 <= RST_VAL;
    end else begin
      stage1 <= pins_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  // ********************************************************************
  // Agreement filter
  // ********************************************************************
  always_ff @(posedge core_clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      pins_o <= RST_VAL;
    end else begin
      for (int i = 0; i < WIDTH; i++) begin
        if (stage2[i] == stage3[i]) begin
          pins_o[i] <= stage3[i];
        end
      end
    end
  end

endmodule

// *** dv/spi_host_model.sv ***
// Host side model: drives mode 0 serial frames one byte at a time
`timescale 1ns/1ps
module spi_host_model (
  input  wire logic core_clk_i,
  input  wire logic spi_sdo_i,
  output logic      spi_sclk_o,
  output logic      spi_cs_n_o,
  output logic      spi_sdi_o
);
  // Each serial phase lasts this many core clocks, above the pin filter delay
  localparam int HALF = 8;

  initial begin
    spi_sclk_o = 1'b0;
    spi_cs_n_o = 1'b1;
    spi_sdi_o  = 1'b0;
  end

  task automatic idle(input int n);
    repeat (n) @(negedge core_clk_i);
  endtask

  // ********************************************************************
  // Frame control
  // ********************************************************************
  task automatic open_frame();
    idle(1);
    spi_cs_n_o = 1'b0;
    idle(HALF);
  endtask

  // Serial clock stands low between frames; data line shows no stale bit
  task automatic close_frame();
    idle(HALF);
    spi_cs_n_o = 1'b1;
    spi_sdi_o  = ~spi_sdi_o;
    idle(2 * HALF);
  endtask

  // MSB first; host supplies whole bytes, so crc bytes travel intact
  task automatic shift_byte(input logic [7:0] tx, output logic [7:0] rx);
    for (int i = 7; i >= 0; i--) begin
      spi_sdi_o  = tx[i];
      idle(HALF);
      rx[i]      = spi_sdo_i;
      spi_sclk_o = 1'b1;
      idle(HALF);
      spi_sclk_o = 1'b0;
    end
  endtask
endmodule

// *** dv/spi_switch_regs_tb.sv ***
// Self-checking bench for the switch register bank
`timescale 1ns/1ps
module spi_switch_regs_tb;
  import spi_sw_pkg::*;
  logic        core_clk;
  logic        resetn;
  logic        sclk;
  logic        cs_n;
  logic        sdi;
  logic        sdo;
  logic        sdo_oe;
  switch_vec_t sw;
  reg_byte_t   rdat;
  logic        crc_on;
  logic        bad_crc;
  int          err_total = 0;
  int          n_tests   = 0;
  int          cyc       = 0;

  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  spi_switch_regs i_dut (
    .core_clk_i     (core_clk),
    .resetn_i       (resetn),
    .spi_sclk_i     (sclk),
    .spi_cs_n_i     (cs_n),
    .spi_sdi_i      (sdi),
    .spi_sdo_o      (sdo),
    .spi_sdo_oe_o   (sdo_oe),
    .switch_close_o (sw)
  );

  spi_host_model i_host (
    .core_clk_i (core_clk),
    .spi_sdo_i  (sdo),
    .spi_sclk_o (sclk),
    .spi_cs_n_o (cs_n),
    .spi_sdi_o  (sdi)
  );

  // ********************************************************************
  // Helpers
  // ********************************************************************
  function automatic logic [7:0] crc8(input logic [15:0] p);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 15; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ (((c[7] ^ p[i]) == 1'b1) ? 8'h07 : 8'h00);
    end
    return c;
  endfunction

  task automatic wrap_up();
    if (err_total == 0 && n_tests > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_tests++;
    if (got !== exp) begin
      err_total++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cmd(input logic rw, input logic [6:0] a, input logic [7:0] d);
    logic [7:0] r;
    logic [7:0] c;
    i_host.shift_byte({rw, a}, r);
    chk(r, 8'h25);
    i_host.shift_byte(d, rdat);
    if (crc_on) begin
      i_host.shift_byte(crc8({rw, a, d}) ^ {8{bad_crc}}, c);
      if (rw) chk(c, crc8({rw, a, rdat}));
    end
  endtask

  task automatic xfer(input logic rw, input logic [6:0] a, input logic [7:0] d);
    i_host.open_frame();
    cmd(rw, a, d);
    i_host.close_frame();
  endtask

  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    xfer(1'b0, a, d);
  endtask

  task automatic rd(input logic [6:0] a, input logic [7:0] exp);
    xfer(1'b1, a, 8'h00);
    chk(rdat, exp);
  endtask

  task automatic sw_is(input logic [7:0] exp);
    chk({4'h0, sw}, exp);
  endtask

  // Frame carrying an extra byte, or only the address byte
  task automatic odd_frame(input logic longer);
    i_host.open_frame();
    if (longer) begin
      cmd(1'b0, 7'h01, 8'h03);
    end
    i_host.shift_byte(8'h01, rdat);
    i_host.close_frame();
  endtask

  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (cyc == 40000) begin
      err_total++;
      wrap_up();
    end
  end

  // ********************************************************************
  // Test sequence
  // ********************************************************************
  initial begin
    resetn  = 1'b0;
    crc_on  = 1'b0;
    bad_crc = 1'b0;
    repeat (6) @(negedge core_clk);
    resetn = 1'b1;
    repeat (6) @(negedge core_clk);
    sw_is(8'h00);
    rd(7'h02, 8'h06);
    rd(7'h03, 8'h00);
    rd(7'h05, 8'h00);
    rd(7'h0b, 8'h00);
    for (int i = 0; i < 4; i++) begin
      wr(7'h01, 8'h01 << i);
      sw_is(8'h01 << i);
    end
    rd(7'h01, 8'h08);
    xfer(1'b1, 7'h04, 8'h00);
    rd(7'h03, 8'h04);
    wr(7'h6c, 8'ha9);
    rd(7'h03, 8'h00);
    wr(7'h03, 8'h07);
    rd(7'h03, 8'h04);
    wr(7'h6c, 8'ha9);
    wr(7'h04, 8'h01);
    rd(7'h03, 8'h04);
    sw_is(8'h08);
    wr(7'h6c, 8'ha9);
    odd_frame(1'b0);
    rd(7'h03, 8'h02);
    wr(7'h6c, 8'ha9);
    odd_frame(1'b1);
    sw_is(8'h03);
    rd(7'h03, 8'h02);
    wr(7'h6c, 8'ha9);
    wr(7'h02, 8'h02);
    xfer(1'b1, 7'h04, 8'h00);
    rd(7'h03, 8'h00);
    wr(7'h02, 8'h04);
    odd_frame(1'b0);
    rd(7'h03, 8'h00);
    wr(7'h02, 8'h07);
    crc_on = 1'b1;
    wr(7'h01, 8'h0c);
    sw_is(8'h0c);
    bad_crc = 1'b1;
    wr(7'h01, 8'h03);
    bad_crc = 1'b0;
    sw_is(8'h0c);
    rd(7'h03, 8'h01);
    bad_crc = 1'b1;
    wr(7'h6c, 8'ha9);
    bad_crc = 1'b0;
    rd(7'h03, 8'h01);
    wr(7'h6c, 8'ha9);
    rd(7'h03, 8'h00);
    crc_on = 1'b0;
    wr(7'h01, 8'h05);
    crc_on = 1'b1;
    sw_is(8'h0c);
    rd(7'h03, 8'h02);
    wr(7'h6c, 8'ha9);
    wr(7'h02, 8'h06);
    crc_on = 1'b0;
    wr(7'h05, 8'h01);
    i_host.open_frame();
    chk({7'h00, sdo_oe}, 8'h01);
    cmd(1'b0, 7'h01, 8'h06);
    cmd(1'b1, 7'h05, 8'h00);
    chk(rdat, 8'h01);
    i_host.close_frame();
    chk({7'h00, sdo_oe}, 8'h00);
    sw_is(8'h06);
    rd(7'h03, 8'h00);
    odd_frame(1'b1);
    rd(7'h03, 8'h02);
    wr(7'h6c, 8'ha9);
    wr(7'h0b, 8'ha3);
    wr(7'h01, 8'h0f);
    wr(7'h0b, 8'h05);
    sw_is(8'h0f);
    rd(7'h05, 8'h01);
    rd(7'h0b, 8'h05);
    wr(7'h0b, 8'ha3);
    wr(7'h0b, 8'h05);
    sw_is(8'h00);
    rd(7'h05, 8'h00);
    rd(7'h02, 8'h06);
    rd(7'h0b, 8'h00);
    wrap_up();
  end
endmodule
